// ---- design/pvd_sink.sv ----
`timescale 1ns/100ps
`include "pvd_defs.svh"

// How it works
// - source answers sink request with accept
// - sink starts transition timer on accept
// - goodcrc for accept before acting on it
// - source waits transition time after goodcrc
// - sink drops to standby within standby time
// - source supply moves, ready within bound
// - supply ready makes source send ps_rdy
// - sink returns goodcrc for ps_rdy
// - goodcrc for ps_rdy ends source side
// - sink permits new power after ps_rdy
// - sink draws new power, no fixed latency

module pvd_sink
#(
    parameter logic [`PVD_CNT_W-1:0] PS_TRANS_CYC = `PVD_CNT_W'(`PVD_T_PS_TRANSITION_US * `PVD_CLK_MHZ),
    parameter logic [`PVD_CNT_W-1:0] SNK_STDBY_CYC = `PVD_CNT_W'(`PVD_T_SNK_STDBY_US * `PVD_CLK_MHZ)
)
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // link to source
    pvd_link_if.snk   link,
    // policy manager side
    input  wire logic start,
    output logic      busy,
    output logic      done,
    output logic      fail,
    // supply through device policy manager
    output logic      standby_cmd,
    input  wire logic standby_reached,
    output logic      standby_late,
    output logic      new_power_ok
);

    pvd_pkg::pvd_snk_state_t state;
    pvd_pkg::pvd_snk_state_t next_state;
    logic [`PVD_CNT_W-1:0]   ps_cnt;
    logic [`PVD_CNT_W-1:0]   sb_cnt;
    logic                    ps_run;
    logic                    sb_run;
    logic                    ps_expired;
    logic                    sb_expired;
    logic                    got_acc;
    logic                    got_rdy;

    // ==========================================================
    // message decode and timer ends
    assign got_acc    = link.src_valid && (link.src_msg == pvd_pkg::PVD_MSG_ACCEPT);
    assign got_rdy    = link.src_valid && (link.src_msg == pvd_pkg::PVD_MSG_PS_RDY);
    assign ps_expired = ps_run && (ps_cnt == `PVD_CNT_ONE);
    assign sb_expired = sb_run && (sb_cnt == `PVD_CNT_ONE);

    // ==========================================================
    // next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            pvd_pkg::PVD_SNK_IDLE:
            begin
                if (start)
                begin
                    next_state = pvd_pkg::PVD_SNK_WAIT_ACC;
                end
            end
            pvd_pkg::PVD_SNK_WAIT_ACC:
            begin
                if (got_acc)
                begin
                    next_state = pvd_pkg::PVD_SNK_ACK_ACC;
                end
            end
            pvd_pkg::PVD_SNK_ACK_ACC:
            begin
                next_state = pvd_pkg::PVD_SNK_STDBY;
            end
            pvd_pkg::PVD_SNK_STDBY:
            begin
                if (got_rdy)
                begin
                    next_state = pvd_pkg::PVD_SNK_ACK_RDY;
                end
                else if (ps_expired)
                begin
                    next_state = pvd_pkg::PVD_SNK_IDLE;
                end
            end
            pvd_pkg::PVD_SNK_ACK_RDY:
            begin
                next_state = pvd_pkg::PVD_SNK_EVAL;
            end
            pvd_pkg::PVD_SNK_EVAL:
            begin
                next_state = pvd_pkg::PVD_SNK_IDLE;
            end
            default:
            begin
                next_state = pvd_pkg::PVD_SNK_IDLE;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= pvd_pkg::PVD_SNK_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ==========================================================
    // transition timer
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ps_run <= 1'b0;
            ps_cnt <= `PVD_CNT_ZERO;
        end
        else if (state == pvd_pkg::PVD_SNK_WAIT_ACC && got_acc)
        begin
            ps_run <= 1'b1;
            ps_cnt <= PS_TRANS_CYC;
        end
        else if (got_rdy || ps_expired)
        begin
            ps_run <= 1'b0;
            ps_cnt <= `PVD_CNT_ZERO;
        end
        else if (ps_run)
        begin
            ps_cnt <= ps_cnt - `PVD_CNT_ONE;
        end
    end

    // ==========================================================
    // standby deadline timer
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sb_run <= 1'b0;
            sb_cnt <= `PVD_CNT_ZERO;
        end
        else if (state == pvd_pkg::PVD_SNK_ACK_ACC)
        begin
            sb_run <= 1'b1;
            sb_cnt <= SNK_STDBY_CYC;
        end
        else if (standby_reached || sb_expired || state == pvd_pkg::PVD_SNK_IDLE)
        begin
            sb_run <= 1'b0;
            sb_cnt <= `PVD_CNT_ZERO;
        end
        else if (sb_run)
        begin
            sb_cnt <= sb_cnt - `PVD_CNT_ONE;
        end
    end

    // ==========================================================
    // outgoing request and goodcrc
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            link.snk_valid <= 1'b0;
            link.snk_msg   <= pvd_pkg::PVD_MSG_NONE;
            link.snk_crc   <= 1'b0;
        end
        else
        begin
            link.snk_valid <= (state == pvd_pkg::PVD_SNK_IDLE) && start;
            link.snk_msg   <= ((state == pvd_pkg::PVD_SNK_IDLE) && start) ?
                              pvd_pkg::PVD_MSG_REQUEST : pvd_pkg::PVD_MSG_NONE;
            link.snk_crc   <= (state == pvd_pkg::PVD_SNK_WAIT_ACC && got_acc) ||
                              (state == pvd_pkg::PVD_SNK_STDBY && got_rdy);
        end
    end

    // ==========================================================
    // supply command toward standby
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            standby_cmd <= 1'b0;
        end
        else if (state == pvd_pkg::PVD_SNK_ACK_ACC)
        begin
            standby_cmd <= 1'b1;
        end
        else if (state == pvd_pkg::PVD_SNK_EVAL || state == pvd_pkg::PVD_SNK_IDLE)
        begin
            standby_cmd <= 1'b0;
        end
    end

    // ==========================================================
    // new power permission, held until next request
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            new_power_ok <= 1'b0;
        end
        else if (state == pvd_pkg::PVD_SNK_EVAL)
        begin
            new_power_ok <= 1'b1;
        end
        else if (state == pvd_pkg::PVD_SNK_IDLE && start)
        begin
            new_power_ok <= 1'b0;
        end
    end

    // ==========================================================
    // status pulses
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            done         <= 1'b0;
            fail         <= 1'b0;
            standby_late <= 1'b0;
        end
        else
        begin
            done         <= (state == pvd_pkg::PVD_SNK_EVAL);
            fail         <= (state == pvd_pkg::PVD_SNK_STDBY) && ps_expired && !got_rdy;
            standby_late <= sb_expired && !standby_reached;
        end
    end

    // busy from state flops
    assign busy = (state != pvd_pkg::PVD_SNK_IDLE);

endmodule

// ---- design/pvd_defs.svh ----
`ifndef PVD_DEFS_SVH
`define PVD_DEFS_SVH

// ==========================================================
// clock rate
`define PVD_CLK_MHZ             200

// ==========================================================
// timing figures, in microseconds
`define PVD_T_SNK_TRANSITION_US 35
`define PVD_T_SRC_READY_US      285
`define PVD_T_SNK_STDBY_US      15
`define PVD_T_PS_TRANSITION_US  500
`define PVD_T_CRC_WAIT_US       1

// ==========================================================
// timer counter
`define PVD_CNT_W               24
`define PVD_CNT_ZERO            24'h000000
`define PVD_CNT_ONE             24'h000001

`endif

// ---- design/pvd_pkg.sv ----
package pvd_pkg;

    // ==========================================================
    // message kinds on the link
    typedef enum logic [1:0]
    {
        PVD_MSG_NONE    = 2'h0,
        PVD_MSG_REQUEST = 2'h1,
        PVD_MSG_ACCEPT  = 2'h2,
        PVD_MSG_PS_RDY  = 2'h3
    } pvd_msg_t;

    // ==========================================================
    // source states
    typedef enum logic [4:0]
    {
        PVD_SRC_IDLE     = 5'h01,
        PVD_SRC_CRC_ACC  = 5'h02,
        PVD_SRC_TRANS    = 5'h04,
        PVD_SRC_SUPPLY   = 5'h08,
        PVD_SRC_CRC_RDY  = 5'h10
    } pvd_src_state_t;

    // ==========================================================
    // sink states
    typedef enum logic [5:0]
    {
        PVD_SNK_IDLE     = 6'h01,
        PVD_SNK_WAIT_ACC = 6'h02,
        PVD_SNK_ACK_ACC  = 6'h04,
        PVD_SNK_STDBY    = 6'h08,
        PVD_SNK_ACK_RDY  = 6'h10,
        PVD_SNK_EVAL     = 6'h20
    } pvd_snk_state_t;

endpackage

// ---- design/pvd_link_if.sv ----
`timescale 1ns/100ps

// ==========================================================
// message link between source and sink policy engines
interface pvd_link_if;
    logic              src_valid;
    pvd_pkg::pvd_msg_t src_msg;
    logic              snk_valid;
    pvd_pkg::pvd_msg_t snk_msg;
    logic              snk_crc;

    modport src
    (
        output src_valid,
        output src_msg,
        input  snk_valid,
        input  snk_msg,
        input  snk_crc
    );

    modport snk
    (
        input  src_valid,
        input  src_msg,
        output snk_valid,
        output snk_msg,
        output snk_crc
    );
endinterface

// ---- design/pvd_source.sv ----
`timescale 1ns/100ps
`include "pvd_defs.svh"

module pvd_source
#(
    parameter logic [`PVD_CNT_W-1:0] SNK_TRANS_CYC = `PVD_CNT_W'(`PVD_T_SNK_TRANSITION_US * `PVD_CLK_MHZ),
    parameter logic [`PVD_CNT_W-1:0] SRC_READY_CYC = `PVD_CNT_W'(`PVD_T_SRC_READY_US * `PVD_CLK_MHZ),
    parameter logic [`PVD_CNT_W-1:0] CRC_WAIT_CYC  = `PVD_CNT_W'(`PVD_T_CRC_WAIT_US * `PVD_CLK_MHZ)
)
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // link to sink
    pvd_link_if.src   link,
    // supply through device policy manager
    output logic      supply_cmd,
    input  wire logic supply_ready,
    // status
    output logic      busy,
    output logic      done,
    output logic      fail
);

    pvd_pkg::pvd_src_state_t state;
    pvd_pkg::pvd_src_state_t next_state;
    logic [`PVD_CNT_W-1:0]   cnt;
    logic [`PVD_CNT_W-1:0]   next_cnt;
    logic                    expired;
    logic                    got_req;
    logic                    got_crc;

    assign expired = (cnt == `PVD_CNT_ONE);
    assign got_req = link.snk_valid && (link.snk_msg == pvd_pkg::PVD_MSG_REQUEST);
    assign got_crc = link.snk_crc;

    // ==========================================================
    // next state and timer load
    always_comb
    begin
        next_state = state;
        next_cnt   = (cnt == `PVD_CNT_ZERO) ? cnt : cnt - `PVD_CNT_ONE;
        unique case (state)
            pvd_pkg::PVD_SRC_IDLE:
            begin
                if (got_req)
                begin
                    next_state = pvd_pkg::PVD_SRC_CRC_ACC;
                    next_cnt   = CRC_WAIT_CYC;
                end
            end
            pvd_pkg::PVD_SRC_CRC_ACC:
            begin
                if (got_crc)
                begin
                    next_state = pvd_pkg::PVD_SRC_TRANS;
                    next_cnt   = SNK_TRANS_CYC;
                end
                else if (expired)
                begin
                    next_state = pvd_pkg::PVD_SRC_IDLE;
                end
            end
            pvd_pkg::PVD_SRC_TRANS:
            begin
                if (expired)
                begin
                    next_state = pvd_pkg::PVD_SRC_SUPPLY;
                    next_cnt   = SRC_READY_CYC;
                end
            end
            pvd_pkg::PVD_SRC_SUPPLY:
            begin
                if (supply_ready)
                begin
                    next_state = pvd_pkg::PVD_SRC_CRC_RDY;
                    next_cnt   = CRC_WAIT_CYC;
                end
                else if (expired)
                begin
                    next_state = pvd_pkg::PVD_SRC_IDLE;
                end
            end
            pvd_pkg::PVD_SRC_CRC_RDY:
            begin
                if (got_crc || expired)
                begin
                    next_state = pvd_pkg::PVD_SRC_IDLE;
                end
            end
            default:
            begin
                next_state = pvd_pkg::PVD_SRC_IDLE;
            end
        endcase
    end

    // ==========================================================
    // state and timer
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= pvd_pkg::PVD_SRC_IDLE;
            cnt   <= `PVD_CNT_ZERO;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // ==========================================================
    // outgoing messages
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            link.src_valid <= 1'b0;
            link.src_msg   <= pvd_pkg::PVD_MSG_NONE;
        end
        else if (state == pvd_pkg::PVD_SRC_IDLE && got_req)
        begin
            link.src_valid <= 1'b1;
            link.src_msg   <= pvd_pkg::PVD_MSG_ACCEPT;
        end
        else if (state == pvd_pkg::PVD_SRC_SUPPLY && supply_ready)
        begin
            link.src_valid <= 1'b1;
            link.src_msg   <= pvd_pkg::PVD_MSG_PS_RDY;
        end
        else
        begin
            link.src_valid <= 1'b0;
            link.src_msg   <= pvd_pkg::PVD_MSG_NONE;
        end
    end

    // ==========================================================
    // status pulses
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            done <= 1'b0;
            fail <= 1'b0;
        end
        else
        begin
            done <= (state == pvd_pkg::PVD_SRC_CRC_RDY) && got_crc;
            // only waiting states may time out; the idle count run-down is not a failure
            fail <= expired && ((((state == pvd_pkg::PVD_SRC_CRC_ACC) || (state == pvd_pkg::PVD_SRC_CRC_RDY))
                                 && !got_crc) ||
                                ((state == pvd_pkg::PVD_SRC_SUPPLY) && !supply_ready));
        end
    end

    // supply command and busy straight from state flops
    assign supply_cmd = (state == pvd_pkg::PVD_SRC_SUPPLY);
    assign busy       = (state != pvd_pkg::PVD_SRC_IDLE);

endmodule

// ---- sim/pvd_link_asserts.sv ----
`timescale 1ns/100ps

// ==========================================================
// link and supply checks between source and sink
module pvd_link_asserts
(
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              nrst,
    // link signals
    input wire logic              src_valid,
    input wire pvd_pkg::pvd_msg_t src_msg,
    input wire logic              snk_valid,
    input wire pvd_pkg::pvd_msg_t snk_msg,
    input wire logic              snk_crc,
    // source supply handshake
    input wire logic              supply_cmd,
    input wire logic              supply_ready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    accept_after_req_a:
        assert property (src_valid && src_msg == pvd_pkg::PVD_MSG_ACCEPT
            |-> $past(snk_valid && snk_msg == pvd_pkg::PVD_MSG_REQUEST)) else $error("accept without request");
    req_code_a:
        assert property (snk_valid |-> snk_msg == pvd_pkg::PVD_MSG_REQUEST) else $error("bad sink code");
    acc_crc_a:
        assert property (src_valid && src_msg == pvd_pkg::PVD_MSG_ACCEPT |=> snk_crc) else $error("no crc for accept");
    crc_cause_a:
        assert property (snk_crc |-> $past(src_valid)) else $error("crc without message");
    trans_wait_a:
        assert property ((src_valid && src_msg == pvd_pkg::PVD_MSG_ACCEPT) ##1 snk_crc
            |=> !supply_cmd [*6] ##[1:4] supply_cmd) else $error("supply command timing");
    rdy_cause_a:
        assert property (src_valid && src_msg == pvd_pkg::PVD_MSG_PS_RDY
            |-> $past(supply_cmd && supply_ready)) else $error("ready message without supply");
    cmd_drop_a:
        assert property (supply_cmd && supply_ready
            |=> !supply_cmd && src_valid && src_msg == pvd_pkg::PVD_MSG_PS_RDY) else $error("no ready message");
    rdy_crc_a:
        assert property (src_valid && src_msg == pvd_pkg::PVD_MSG_PS_RDY |=> snk_crc) else $error("no crc for ready");
    src_pulse_a:
        assert property (src_valid |=> !src_valid) else $error("source valid too long");
    src_idle_a:
        assert property (!src_valid |-> src_msg == pvd_pkg::PVD_MSG_NONE) else $error("source code when idle");
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps

// ==========================================================
// bench for the source and sink sequencer pair
module tb;
    logic sys_clk, nrst, start, standby_reached, supply_ready, supply_cmd;
    logic src_busy, src_done, src_fail, snk_busy, snk_done, snk_fail;
    logic standby_cmd, standby_late, new_power_ok;
    int   n_mismatch, check_count, cyc, n_req, n_acc, n_late, rdy_dly, stb_dly, rdy_cnt, stb_cnt, n, n_sfail;

    pvd_link_if link ();

    pvd_source #(.SNK_TRANS_CYC(24'h000008), .SRC_READY_CYC(24'h000010), .CRC_WAIT_CYC(24'h000008)) pvd_source_inst
    (
        .sys_clk(sys_clk), .nrst(nrst), .link(link), .supply_cmd(supply_cmd), .supply_ready(supply_ready),
        .busy(src_busy), .done(src_done), .fail(src_fail)
    );

    pvd_sink #(.PS_TRANS_CYC(24'h000040), .SNK_STDBY_CYC(24'h000004)) pvd_sink_inst
    (
        .sys_clk(sys_clk), .nrst(nrst), .link(link), .start(start), .busy(snk_busy), .done(snk_done),
        .fail(snk_fail), .standby_cmd(standby_cmd), .standby_reached(standby_reached),
        .standby_late(standby_late), .new_power_ok(new_power_ok)
    );

    pvd_link_asserts pvd_link_asserts_inst
    (
        .sys_clk(sys_clk), .nrst(nrst), .src_valid(link.src_valid), .src_msg(link.src_msg),
        .snk_valid(link.snk_valid), .snk_msg(link.snk_msg), .snk_crc(link.snk_crc),
        .supply_cmd(supply_cmd), .supply_ready(supply_ready)
    );

    // clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // supplies answer after a set delay; link counts; hang guard
    always @(posedge sys_clk)
    begin
        rdy_cnt <= supply_cmd ? rdy_cnt + 1 : 0;
        supply_ready <= supply_cmd && rdy_cnt >= rdy_dly;
        stb_cnt <= standby_cmd ? stb_cnt + 1 : 0;
        standby_reached <= standby_cmd && stb_cnt >= stb_dly;
        n_req <= n_req + (link.snk_valid === 1'b1);
        n_acc <= n_acc + (link.src_valid === 1'b1 && link.src_msg === pvd_pkg::PVD_MSG_ACCEPT);
        n_late <= n_late + (standby_late === 1'b1);
        n_sfail <= n_sfail + (src_fail === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    task chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_num(input int got, input int exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // event selector for bounded waits
    function automatic logic probe(input int sel);
        case (sel)
            0: return link.src_valid && link.src_msg == pvd_pkg::PVD_MSG_PS_RDY;
            1: return src_done;
            2: return snk_done;
            3: return src_fail;
            default: return snk_fail;
        endcase
    endfunction

    task wait_for(input int sel, output int k);
        k = 0;
        while (probe(sel) !== 1'b1 && k < 200)
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        chk_bit(probe(sel), 1'b1);
    endtask

    // one request from the sink policy manager
    task run(input int rd, input int sd);
        rdy_dly = rd;
        stb_dly = sd;
        @(posedge sys_clk);
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task end_sim;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {nrst, start} = 2'h0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        // normal transfer, second start while busy
        run(2, 1);
        @(posedge sys_clk);
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        wait_for(0, n);
        wait_for(1, n);
        chk_num(n, 2);
        wait_for(2, n);
        chk_num(n, 1);
        repeat (5) @(posedge sys_clk);
        #1;
        chk_bit(new_power_ok, 1'b1);
        chk_bit(src_busy, 1'b0);
        chk_num(n_req, 1);
        chk_num(n_acc, 1);
        chk_num(n_late, 0);
        chk_bit(standby_cmd, 1'b0);
        $display("test 1 done");
        // late standby is flagged, transfer still completes
        run(2, 10);
        chk_bit(new_power_ok, 1'b0);
        wait_for(2, n);
        chk_num(n_late, 1);
        chk_bit(new_power_ok, 1'b1);
        chk_num(n_sfail, 0);
        $display("test 2 done");
        // supply never ready: source fails, sink timer expires
        run(100, 1);
        wait_for(3, n);
        chk_bit(supply_cmd, 1'b0);
        chk_bit(standby_cmd, 1'b1);
        wait_for(4, n);
        chk_bit(new_power_ok, 1'b0);
        chk_bit(snk_busy, 1'b0);
        chk_num(n_sfail, 1);
        $display("test 3 done");
        // reset in mid transfer, then a clean run
        run(2, 1);
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk_bit(src_busy, 1'b0);
        chk_bit(snk_busy, 1'b0);
        @(posedge sys_clk);
        nrst <= 1'b1;
        run(3, 2);
        wait_for(2, n);
        chk_bit(new_power_ok, 1'b1);
        $display("test 4 done");
        end_sim();
    end
endmodule
